// ### bench/dbs_properties.sv
// Purpose: Pin-level checks between the device end and the controller end.
// Assumes: One clock; drivers enable low.
// Notes: Reads are never followed by a write without a bus gap.
`timescale 1ns/10ps
module dbs_properties (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic load_command_n,
  input wire logic read_not_write,
  input wire logic termination_select,
  input wire logic dev_dq_oe_n,
  input wire logic ctl_dq_oe_n
);
  logic rd_cmd;
  assign rd_cmd = !load_command_n && read_not_write;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence rd_s;
    !load_command_n && read_not_write;
  endsequence
  sequence wr_s;
    !load_command_n && !read_not_write;
  endsequence
  sequence pair_s(x);
    !x ##1 !x;
  endsequence
  read_burst_a: assert property (rd_s |-> ##3 pair_s(dev_dq_oe_n))
    else $error("read beats not driven");
  desel_drain_a: assert property (rd_s ##1 load_command_n |-> ##2 pair_s(dev_dq_oe_n))
    else $error("deselect cut a read short");
  idle_float_a: assert property (!dev_dq_oe_n |-> $past(rd_cmd, 3) || $past(rd_cmd, 4))
    else $error("device drove outside a read");
  write_off_a: assert property (wr_s |-> ##3 dev_dq_oe_n)
    else $error("device drove after write");
  nop_low_a: assert property (load_command_n && !termination_select && !$past(rd_cmd)
    |-> ##3 dev_dq_oe_n)
    else $error("device drove after nop");
  nop_high_a: assert property (load_command_n && termination_select && !$past(rd_cmd)
    |-> ##3 dev_dq_oe_n)
    else $error("device drove after nop");
  write_beats_a: assert property (wr_s |=> pair_s(ctl_dq_oe_n))
    else $error("write beats missing");
  bus_clash_a: assert property (dev_dq_oe_n || ctl_dq_oe_n)
    else $error("both ends drive data");
endmodule

// ### bench/test_ddr_burst2_sram_command_path.sv
// Purpose: Random traffic through both ends against a memory model.
// Assumes: Reads of lanes never written come back unknown in both.
// Notes: Four idle cycles follow a read before any write.
`timescale 1ns/10ps
module test_ddr_burst2_sram_command_path;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic vld = 1'b0;
  logic rd = 1'b0;
  logic tsel = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [3:0] mk = 4'hf;
  logic rdy;
  logic rv;
  logic [15:0] rdat;
  logic [7:0] mem_m [256];
  logic [15:0] exp_q [$];
  int mismatches = 0;
  int checks_done = 0;
  always #5 core_clk_in = ~core_clk_in;
  dbs_if bus ();
  dbs_device dbs_device_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .pins(bus));
  dbs_ctrl dbs_ctrl_inst (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(vld),
    .req_read_in(rd), .req_addr_in(addr), .req_wdata_in(wd), .req_mask_n_in(mk),
    .term_sel_in(tsel), .req_ready_out(rdy), .rd_data_out(rdat), .rd_valid_out(rv),
    .pins(bus));
  dbs_properties dbs_properties_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .load_command_n(bus.load_command_n), .read_not_write(bus.read_not_write),
    .termination_select(bus.termination_select), .dev_dq_oe_n(bus.dev_dq_oe_n),
    .ctl_dq_oe_n(bus.ctl_dq_oe_n));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle(input int n);
    vld = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  // Memory model: beat one to the base address, beat two to the next, per half-byte lane.
  task automatic issue();
    int n;
    logic [7:0] a1;
    a1 = addr + 8'h01;
    vld = 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_in);
      if (rdy === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      stop_test();
    end
    #1;
    if (rd) exp_q.push_back({mem_m[a1], mem_m[addr]});
    for (n = 0; n < 2 && !rd; n++) begin
      if (!mk[n]) mem_m[addr][n*4 +: 4] = wd[n*4 +: 4];
      if (!mk[n+2]) mem_m[a1][n*4 +: 4] = wd[8+n*4 +: 4];
    end
  endtask
  always @(posedge core_clk_in) begin
    if (!rst_in && rv === 1'b1) begin
      if (exp_q.size() > 0) check(rdat, exp_q.pop_front());
      else begin
        mismatches++;
        $display("ERROR at %0t: got %h expected %h", $time, rdat, 16'h0000);
      end
    end
  end
  initial begin
    int i;
    logic prev;
    prev = 1'b0;
    void'($urandom(96085));
    idle(20);
    rst_in = 1'b0;
    for (i = 0; i < 400; i++) begin
      if (i == 200) begin
        idle(8);
        rst_in = 1'b1;
        idle(2);
        rst_in = 1'b0;
      end
      rd = (i > 30) && ($urandom_range(1) == 1);
      if (!rd && prev) idle(4);
      if ($urandom_range(3) == 0) idle(1);
      tsel = $urandom_range(1);
      addr = (i % 16 == 0) ? 8'hff : 8'($urandom_range(15));
      wd = 16'($urandom);
      mk = 4'($urandom_range(15));
      issue();
      prev = rd;
    end
    idle(12);
    check(16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule

// ### hdl/dbs_ctrl.sv
`timescale 1ns/10ps
// Purpose: Controller end: issues commands and drives write beats with lane masks.
// Assumes: User side asks one command per cycle; write data and masks come with the request.
// Notes: Read data is captured three and four cycles after the read command is on the pins.
module dbs_ctrl (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_read_in,
  input wire logic [dbs_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [2*dbs_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic [2*dbs_pkg::LANES-1:0] req_mask_n_in,
  input wire logic term_sel_in,
  output logic req_ready_out,
  output logic [2*dbs_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  dbs_if.ctrl pins
);
  typedef struct packed {
    logic [dbs_pkg::READ_LAT+2:0] rd_pipe;
    logic [1:0] wr_beat;
    logic [dbs_pkg::DATA_W-1:0] wr_lo;
    logic [dbs_pkg::LANES-1:0] mask_lo;
    logic [dbs_pkg::DATA_W-1:0] wr_hi;
    logic [dbs_pkg::LANES-1:0] mask_hi;
    logic [2*dbs_pkg::DATA_W-1:0] rd_data;
    logic rd_valid;
    logic ld_n;
    logic rnw;
    dbs_pkg::dbs_addr_t addr;
    dbs_pkg::dbs_data_t dq_out;
    logic [dbs_pkg::LANES-1:0] mask_n;
    logic dq_oe_n;
  } dbs_ctl_s;
  dbs_ctl_s st_r;
  dbs_ctl_s st_nxt;
  logic issue;

  // Each command takes two beat cycles, so one cycle is left free after every command.
  // A read waits until the write beats are stored; a write waits for the read beats.
  assign req_ready_out = st_r.ld_n && !(req_read_in ? st_r.wr_beat != dbs_pkg::BEAT_NONE :
    |st_r.rd_pipe[dbs_pkg::READ_LAT:0]);
  assign issue = req_valid_in && req_ready_out;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ld_n = !issue;
    st_nxt.rnw = req_read_in;
    st_nxt.addr = req_addr_in;
    st_nxt.rd_pipe = {st_r.rd_pipe[dbs_pkg::READ_LAT+1:0], issue && req_read_in};
    st_nxt.rd_valid = 1'b0;
    if (st_r.rd_pipe[dbs_pkg::READ_LAT+1]) begin
      st_nxt.rd_data[dbs_pkg::DATA_W-1:0] = pins.dq;
    end
    if (st_r.rd_pipe[dbs_pkg::READ_LAT+2]) begin
      st_nxt.rd_data[2*dbs_pkg::DATA_W-1:dbs_pkg::DATA_W] = pins.dq;
      st_nxt.rd_valid = 1'b1;
    end
    // Data drivers idle off; masks idle high.
    st_nxt.dq_oe_n = 1'b1;
    st_nxt.mask_n = dbs_pkg::MASK_NONE;
    case (st_r.wr_beat)
      dbs_pkg::BEAT_FIRST: begin
        st_nxt.dq_out = st_r.wr_lo;
        st_nxt.mask_n = st_r.mask_lo;
        st_nxt.dq_oe_n = 1'b0;
        st_nxt.wr_beat = dbs_pkg::BEAT_SECOND;
      end
      dbs_pkg::BEAT_SECOND: begin
        st_nxt.dq_out = st_r.wr_hi;
        st_nxt.mask_n = st_r.mask_hi;
        st_nxt.dq_oe_n = 1'b0;
        st_nxt.wr_beat = dbs_pkg::BEAT_NONE;
      end
      default: begin
        st_nxt.wr_beat = dbs_pkg::BEAT_NONE;
      end
    endcase
    if (issue && !req_read_in) begin
      st_nxt.wr_lo = req_wdata_in[dbs_pkg::DATA_W-1:0];
      st_nxt.mask_lo = req_mask_n_in[dbs_pkg::LANES-1:0];
      st_nxt.wr_hi = req_wdata_in[2*dbs_pkg::DATA_W-1:dbs_pkg::DATA_W];
      st_nxt.mask_hi = req_mask_n_in[2*dbs_pkg::LANES-1:dbs_pkg::LANES];
      st_nxt.wr_beat = dbs_pkg::BEAT_FIRST;
    end
    if (rst_in) begin
      st_nxt = '0;
      st_nxt.ld_n = 1'b1;
      st_nxt.dq_oe_n = 1'b1;
      st_nxt.mask_n = dbs_pkg::MASK_NONE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
  end

  assign pins.load_command_n = st_r.ld_n;
  assign pins.read_not_write = st_r.rnw;
  assign pins.addr = st_r.addr;
  assign pins.termination_select = term_sel_in;
  assign pins.half_byte_write_mask_n = st_r.mask_n;
  assign pins.ctl_dq_out = st_r.dq_out;
  assign pins.ctl_dq_oe_n = st_r.dq_oe_n;
  assign rd_data_out = st_r.rd_data;
  assign rd_valid_out = st_r.rd_valid;
endmodule

// ### hdl/dbs_device.sv
`timescale 1ns/10ps
// Purpose: Device end: command decode, late write with lane masks, pipelined burst read.
// Assumes: Each core cycle is one data beat; a command cycle is followed by its beat pair.
// Notes: rst_in clears pipeline control, rd_addr, wr_addr and the data drivers; rd_base_r and storage are not reset.
// Behaviour
// - High load strobe means deselect, pins undriven.
// - Write beats are first then second piece.
// - Read beats delivered first piece then second.
// - Termination low: drivers off after idle/write.
// - Termination high: drivers likewise off then.
// - Masks sampled with each data beat.
// - Lane stored only in beats mask low.
// - Mask high both beats stores nothing.
// - Half-byte lanes follow the same beat rules.
// - Mask 0 gates bits 3:0, mask 1 7:4.
// - Controller drives data only in write beats; masks always driven.
// - Deselect only after outstanding bursts finish.
// - Masked lane keeps previous stored contents.
// - Second write beat follows first beat.
module dbs_device (
  input wire logic core_clk_in,
  input wire logic rst_in,
  dbs_if.device pins
);
  typedef struct packed {
    logic [dbs_pkg::READ_LAT:0] rd_pipe;
    logic [1:0] wr_beat;
    dbs_pkg::dbs_addr_t rd_addr;
    dbs_pkg::dbs_addr_t wr_addr;
    dbs_pkg::dbs_data_t dq_out;
    logic dq_oe_n;
  } dbs_dev_s;
  dbs_dev_s st_r;
  dbs_dev_s st_nxt;
  dbs_pkg::dbs_data_t rd_first;
  dbs_pkg::dbs_data_t rd_second;
  dbs_pkg::dbs_addr_t rd_addr_next;
  dbs_pkg::dbs_addr_t rd_base_r;
  dbs_pkg::dbs_addr_t wr_idx;
  logic wr_en;
  dbs_pkg::dbs_cmd_e cmd;

  always_comb begin
    if (pins.load_command_n) begin
      cmd = dbs_pkg::DBS_CMD_DESEL;
    end else if (pins.read_not_write) begin
      cmd = dbs_pkg::DBS_CMD_READ;
    end else begin
      cmd = dbs_pkg::DBS_CMD_WRITE;
    end
  end

  always_comb begin
    st_nxt = st_r;
    wr_en = 1'b0;
    wr_idx = st_r.wr_addr;
    // Commands in flight keep running whatever the strobe now says.
    st_nxt.rd_pipe = {st_r.rd_pipe[dbs_pkg::READ_LAT-1:0], cmd == dbs_pkg::DBS_CMD_READ};
    if (st_r.rd_pipe[0]) begin
      st_nxt.rd_addr = rd_base_r;
    end
    case (st_r.wr_beat)
      dbs_pkg::BEAT_FIRST: begin
        wr_en = 1'b1;
        wr_idx = st_r.wr_addr;
        st_nxt.wr_beat = dbs_pkg::BEAT_SECOND;
      end
      dbs_pkg::BEAT_SECOND: begin
        wr_en = 1'b1;
        wr_idx = st_r.wr_addr + dbs_pkg::ADDR_STEP;
        st_nxt.wr_beat = dbs_pkg::BEAT_NONE;
      end
      default: begin
        st_nxt.wr_beat = dbs_pkg::BEAT_NONE;
      end
    endcase
    if (cmd == dbs_pkg::DBS_CMD_WRITE) begin
      st_nxt.wr_beat = dbs_pkg::BEAT_FIRST;
      st_nxt.wr_addr = pins.addr;
    end
    // Read beats on the pins at n+3 and n+4; any other cycle the drivers are off.
    if (st_r.rd_pipe[1]) begin
      st_nxt.dq_out = rd_first;
      st_nxt.dq_oe_n = 1'b0;
    end else if (st_r.rd_pipe[2]) begin
      st_nxt.dq_out = rd_second;
      st_nxt.dq_oe_n = 1'b0;
    end else begin
      st_nxt.dq_oe_n = 1'b1;
    end
    if (rst_in) begin
      st_nxt.rd_pipe = '0;
      st_nxt.wr_beat = dbs_pkg::BEAT_NONE;
      st_nxt.dq_oe_n = 1'b1;
      st_nxt.dq_out = dbs_pkg::DATA_ZERO;
      st_nxt.rd_addr = dbs_pkg::ADDR_ZERO;
      st_nxt.wr_addr = dbs_pkg::ADDR_ZERO;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_r <= st_nxt;
    if (cmd == dbs_pkg::DBS_CMD_READ) begin
      rd_base_r <= pins.addr;
    end else if (st_r.rd_pipe[0]) begin
      rd_base_r <= rd_base_r;
    end
  end

  // Each half-byte lane is written only in the beats where its mask is low.
  // Each lane keeps its own storage so that no array has two writing processes.
  assign rd_addr_next = st_r.rd_addr + dbs_pkg::ADDR_STEP;
  for (genvar g = 0; g < dbs_pkg::LANES; g++) begin : g_lane
    logic [dbs_pkg::LANE_W-1:0] lane_mem_r [dbs_pkg::DEPTH];
    always_ff @(posedge core_clk_in) begin
      if (wr_en && !pins.half_byte_write_mask_n[g]) begin
        lane_mem_r[wr_idx] <= pins.dq[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
      end
    end
    assign rd_first[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] = lane_mem_r[st_r.rd_addr];
    assign rd_second[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] = lane_mem_r[rd_addr_next];
  end

  assign pins.dev_dq_out = st_r.dq_out;
  assign pins.dev_dq_oe_n = st_r.dq_oe_n;
endmodule

// ### hdl/dbs_if.sv
`timescale 1ns/10ps
// Purpose: Pin bundle between the SRAM device end and the controller end.
// Assumes: Data pins are common I/O, resolved from the two output enables (low = driving).
// Notes: The controller's data input floats between beats; a floating wire reads as all ones.
interface dbs_if;
  logic load_command_n;
  logic read_not_write;
  dbs_pkg::dbs_addr_t addr;
  logic [dbs_pkg::LANES-1:0] half_byte_write_mask_n;
  logic termination_select;
  dbs_pkg::dbs_data_t dev_dq_out;
  logic dev_dq_oe_n;
  dbs_pkg::dbs_data_t ctl_dq_out;
  logic ctl_dq_oe_n;
  dbs_pkg::dbs_data_t dq;
  assign dq = !dev_dq_oe_n ? dev_dq_out : (!ctl_dq_oe_n ? ctl_dq_out : '1);
  modport device (input load_command_n, read_not_write, addr, half_byte_write_mask_n,
    termination_select, dq, output dev_dq_out, dev_dq_oe_n);
  modport ctrl (output load_command_n, read_not_write, addr, half_byte_write_mask_n,
    termination_select, ctl_dq_out, ctl_dq_oe_n, input dq);
endinterface

// ### hdl/dbs_pkg.sv
// Purpose: Shared constants for the burst-of-two SRAM command path.
// Assumes: One core clock; the complement clock edge is modelled as the next core cycle.
// Notes: The 8-bit variant uses two half-byte mask lanes.
package dbs_pkg;
  localparam int DATA_W = 8;
  localparam int LANE_W = 4;
  localparam int LANES = 2;
  localparam int ADDR_W = 8;
  localparam int DEPTH = 256;
  localparam int READ_LAT = 2;
  localparam int WRITE_LAT = 1;
  localparam int IDLE_GAP = 2;
  localparam logic [1:0] BEAT_FIRST = 2'h1;
  localparam logic [1:0] BEAT_SECOND = 2'h2;
  localparam logic [1:0] BEAT_NONE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
  localparam logic [LANES-1:0] MASK_NONE = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
  typedef enum logic [1:0] {DBS_CMD_DESEL, DBS_CMD_WRITE, DBS_CMD_READ} dbs_cmd_e;
  typedef logic [DATA_W-1:0] dbs_data_t;
  typedef logic [ADDR_W-1:0] dbs_addr_t;
endpackage
